// [hdl/mcb_logic_block.sv]
// Logic block: AND array, allocator, clock select and macrocells
`timescale 1ns/1ps
`include "mcb_map.svh"
module mcb_logic_block import mcb_pkg::*; #(
  parameter int NUM_IN = `MCB_NUM_IN,
  parameter int NUM_MC = `MCB_NUM_MC,
  parameter int NUM_PT = NUM_MC * `MCB_CLUSTER_TERMS + 2
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [NUM_IN-1:0] route_in,
  input wire logic [`MCB_NUM_BLK_CLK-1:0] blk_clk_in,
  input wire logic [NUM_PT*NUM_IN-1:0] cfg_and_true_in,
  input wire logic [NUM_PT*NUM_IN-1:0] cfg_and_comp_in,
  input wire logic [NUM_MC-1:0] cfg_async_in,
  input wire logic [NUM_MC-1:0] cfg_extend_in,
  input wire logic [NUM_MC-1:0] cfg_xor_const_in,
  input wire logic [`MCB_ROUTE_W*NUM_MC-1:0] cfg_route_in,
  input wire logic [2*NUM_MC-1:0] cfg_stype_in,
  input wire logic [`MCB_CLK_SEL_W*NUM_MC-1:0] cfg_clk_sel_in,
  input wire logic [NUM_MC-1:0] cfg_clk_pol_in,
  input wire logic [NUM_MC-1:0] cfg_ptclk_en_in,
  input wire logic [NUM_MC-1:0] cfg_ptclk_inv_in,
  input wire logic [NUM_MC-1:0] cfg_data_inv_in,
  output logic [NUM_MC-1:0] mc_out,
  output logic [NUM_MC-1:0] feedback_out,
  output logic [NUM_MC-1:0] jk_latch_warn_out
);
  localparam int CT = `MCB_CLUSTER_TERMS;
  localparam int RST_PT = NUM_MC * CT;
  localparam int PRE_PT = NUM_MC * CT + 1;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [NUM_IN-1:0] route_meta_r;
  logic [NUM_IN-1:0] route_sync_r;
  logic [`MCB_NUM_BLK_CLK-1:0] bclk_meta_r;
  logic [`MCB_NUM_BLK_CLK-1:0] bclk_sync_r;

  // Pins and block clocks are foreign to the core clock
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      route_meta_r <= '0;
      route_sync_r <= '0;
      bclk_meta_r <= '0;
      bclk_sync_r <= '0;
    end else begin
      route_meta_r <= route_in;
      route_sync_r <= route_meta_r;
      bclk_meta_r <= blk_clk_in;
      bclk_sync_r <= bclk_meta_r;
    end
  end

  // ****************************************
  // Product-term array
  // ****************************************
  logic [NUM_PT-1:0] pt;

  // Only routing-matrix signals reach the array, own outputs included
  mcb_pterm_array #(
    .NUM_IN(NUM_IN),
    .NUM_PT(NUM_PT)
  ) u_array (
    .sig_in(route_sync_r),
    .true_en_in(cfg_and_true_in),
    .comp_en_in(cfg_and_comp_in),
    .term_out(pt)
  );

  // ****************************************
  // Configuration decode
  // ****************************************
  mcb_stype_type stype [NUM_MC];
  logic [`MCB_ROUTE_W-1:0] route_off [NUM_MC];
  logic [`MCB_CLK_SEL_W-1:0] clk_sel [NUM_MC];

  genvar g;
  generate
    for (g = 0; g < NUM_MC; g++) begin : g_cfg
      assign stype[g] = mcb_stype_type'(cfg_stype_in[2*g +: 2]);
      assign route_off[g] = cfg_route_in[`MCB_ROUTE_W*g +: `MCB_ROUTE_W];
      assign clk_sel[g] = cfg_clk_sel_in[`MCB_CLK_SEL_W*g +: `MCB_CLK_SEL_W];
    end
  endgenerate

  // ****************************************
  // Logic allocator: clusters
  // ****************************************
  logic [NUM_MC-1:0] basic_sum;
  logic [NUM_MC-1:0] ext_eff;
  logic [NUM_MC-1:0] clus_sum;
  logic [NUM_MC-1:0] xor_b;
  int clus_tgt [NUM_MC];

  // Cluster size is taken from the home macrocell's mode wherever it is steered
  always_comb begin
    for (int c = 0; c < NUM_MC; c++) begin
      clus_tgt[c] = (c + int'(route_off[c])) % NUM_MC;
      basic_sum[c] = pt[c*CT] | pt[c*CT+1];
      if (!cfg_async_in[c]) begin
        basic_sum[c] = basic_sum[c] | pt[c*CT+2] | pt[c*CT+3];
      end
      // Term 2 serves as the product-term clock in asynchronous mode
      // Term 3 is left for the asynchronous initialization, not modelled
      // covered by leaving terms 2 and 3 out of the sum above
      // Toggle type needs the extra term on the XOR, so extension is refused
      ext_eff[c] = cfg_extend_in[c] & (stype[clus_tgt[c]] != MCB_T_REG);
      clus_sum[c] = basic_sum[c] | (ext_eff[c] & pt[c*CT+`MCB_EXTRA_POS]);
      xor_b[c] = ext_eff[c] ? cfg_xor_const_in[c] : pt[c*CT+`MCB_EXTRA_POS];
    end
  end

  // ****************************************
  // Logic allocator: steering and XOR
  // ****************************************
  logic [NUM_MC-1:0] or_sum;
  logic [NUM_MC-1:0] data;

  // Offsets 0..3 let up to four clusters gather on one macrocell
  always_comb begin
    for (int m = 0; m < NUM_MC; m++) begin
      or_sum[m] = 1'h0;
      for (int c = 0; c < NUM_MC; c++) begin
        if (clus_tgt[c] == m) begin
          or_sum[m] = or_sum[m] | clus_sum[c];
        end
      end
      // Split sums on either XOR input give J-K or S-R on D and T types
      data[m] = (or_sum[m] ^ xor_b[m]) ^ cfg_data_inv_in[m];
    end
  end

  // ****************************************
  // Clock select and initialization
  // ****************************************
  logic [NUM_MC-1:0] clk_lvl;
  logic [NUM_MC-1:0] init_rst;
  logic [NUM_MC-1:0] init_pre;

  // Mode steers these two groups and the basic cluster size; storage is untouched
  always_comb begin
    for (int m = 0; m < NUM_MC; m++) begin
      clk_lvl[m] = bclk_sync_r[clk_sel[m]];
      if (cfg_async_in[m] && cfg_ptclk_en_in[m]) begin
        clk_lvl[m] = pt[m*CT+`MCB_PTCLK_POS] ^ cfg_ptclk_inv_in[m];
      end
      init_rst[m] = ~cfg_async_in[m] & pt[RST_PT];
      init_pre[m] = ~cfg_async_in[m] & pt[PRE_PT];
    end
  end

  // ****************************************
  // Storage elements
  // ****************************************
  logic [NUM_MC-1:0] q;

  generate
    for (g = 0; g < NUM_MC; g++) begin : g_mc
      mcb_store u_store (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .clk_lvl_in(clk_lvl[g]),
        .pol_in(cfg_clk_pol_in[g]),
        .stype_in(stype[g]),
        .d_in(data[g]),
        .arst_in(init_rst[g]),
        .apre_in(init_pre[g]),
        .q_out(q[g])
      );
    end
  endgenerate

  // ****************************************
  // Outputs
  // ****************************************
  logic [NUM_MC-1:0] mc_out_r;
  logic [NUM_MC-1:0] mc_out_nxt;
  logic [NUM_MC-1:0] fb_r;
  logic [NUM_MC-1:0] warn_r;
  logic [NUM_MC-1:0] warn_nxt;

  // Bypass costs one core cycle so that every output leaves a flip-flop
  always_comb begin
    for (int m = 0; m < NUM_MC; m++) begin
      mc_out_nxt[m] = (stype[m] == MCB_COMB) ? data[m] : q[m];
      // A latch with the extra term on its XOR is a J-K latch
      warn_nxt[m] = (stype[m] == MCB_D_LATCH) & ~ext_eff[m];
    end
  end

  // Register stage
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mc_out_r <= '0;
      fb_r <= '0;
      warn_r <= '0;
    end else begin
      mc_out_r <= mc_out_nxt;
      fb_r <= mc_out_nxt;
      warn_r <= warn_nxt;
    end
  end

  assign mc_out = mc_out_r;
  assign feedback_out = fb_r;
  assign jk_latch_warn_out = warn_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_comb_sel;
    stype[0] == MCB_COMB;
  endsequence

  sequence s_out_follows;
    mc_out_r[0] == $past(data[0]);
  endsequence

  comb_bypass_a: assert property (s_comb_sel |=> s_out_follows)
    else $error("bypass output did not follow data");
  feedback_same_a: assert property (feedback_out == mc_out)
    else $error("feedback differs from macrocell output");
  sync_size_a: assert property (!cfg_async_in[0] && pt[3] |-> basic_sum[0])
    else $error("synchronous cluster lost its fourth term");
  async_size_a: assert property (cfg_async_in[0] && !pt[0] && !pt[1]
    |-> !basic_sum[0])
    else $error("asynchronous cluster used more than two terms");
  xor_const_a: assert property (ext_eff[0] |-> xor_b[0] == cfg_xor_const_in[0])
    else $error("extended cluster XOR input is not the constant");
  toggle_xor_a: assert property (stype[clus_tgt[0]] == MCB_T_REG
    |-> xor_b[0] == pt[`MCB_EXTRA_POS])
    else $error("toggle cluster extra term not on XOR");
  async_noinit_a: assert property (cfg_async_in[0] |-> !init_rst[0] && !init_pre[0])
    else $error("shared init reached asynchronous macrocell");
  input_sync_a: assert property (route_sync_r == $past(route_in, 2))
    else $error("routing input not delayed by two stages");
endmodule // mcb_logic_block

// [hdl/mcb_map.svh]
// Constants of the product-term logic block and its macrocells
//
// Behaviour
// - Array inputs from routing matrix, true and complement
// - Own feedback returns only through routing matrix
// - Synchronous home macrocell gives 4-term basic cluster
// - Asynchronous home macrocell gives 2-term basic cluster
// - Cluster size follows home macrocell, not target
// - Extra term extends cluster or feeds XOR
// - Four extended clusters reach 20 terms, async 18
// - Extended cluster XOR input is constant 0/1
// - Mode changes clocking, initialization and basic cluster size
// - Combinational bypass selectable in both modes
// - Storage is D register, T register or latch
// - D loads, T toggles, latch transparent enable low
// - Clock or latch enable polarity is programmable
// - J-K and S-R emulated through allocator XOR
// - T, J-K, S-R route extra term to XOR
// - Storage data input polarity programmable
// - Synchronous clock from any of four block clocks
// - Asynchronous mode adds product-term clock, either polarity
// - Synchronous mode: shared reset and preset terms
// - Flag J-K latch configurations, they oscillate
`ifndef MCB_MAP_SVH
`define MCB_MAP_SVH

// ****************************************
// Sizes
// ****************************************
`define MCB_NUM_IN 33
`define MCB_NUM_IN_LARGE 34
`define MCB_NUM_MC 8
`define MCB_NUM_BLK_CLK 4
`define MCB_CLK_SEL_W 2
`define MCB_ROUTE_W 2

// ****************************************
// Cluster layout
// ****************************************
`define MCB_CLUSTER_TERMS 5
`define MCB_SYNC_BASIC 4
`define MCB_ASYNC_BASIC 2
`define MCB_EXTRA_POS 4
`define MCB_PTCLK_POS 2
`define MCB_SYNC_MAX_PT 20
`define MCB_ASYNC_MAX_PT 18

// ****************************************
// Reset values
// ****************************************
`define MCB_Q_RESET 1'h0

`endif

// [hdl/mcb_pkg.sv]
// Types shared by the logic block modules
package mcb_pkg;
  // Storage element configuration
  typedef enum logic [1:0] {
    MCB_D_REG = 2'h0,
    MCB_T_REG = 2'h1,
    MCB_D_LATCH = 2'h2,
    MCB_COMB = 2'h3
  } mcb_stype_type;
endpackage

// [hdl/mcb_pterm_array.sv]
// AND array: each term ANDs chosen true and complement inputs
`timescale 1ns/1ps
`include "mcb_map.svh"
module mcb_pterm_array import mcb_pkg::*; #(
  parameter int NUM_IN = `MCB_NUM_IN,
  parameter int NUM_PT = 8
) (
  input wire logic [NUM_IN-1:0] sig_in,
  input wire logic [NUM_PT*NUM_IN-1:0] true_en_in,
  input wire logic [NUM_PT*NUM_IN-1:0] comp_en_in,
  output logic [NUM_PT-1:0] term_out
);
  // ****************************************
  // Terms
  // ****************************************
  // Unprogrammed term reads as 1, as a blank AND would
  genvar t;
  generate
    for (t = 0; t < NUM_PT; t++) begin : g_term
      assign term_out[t] = &((~true_en_in[t*NUM_IN +: NUM_IN] | sig_in) &
                             (~comp_en_in[t*NUM_IN +: NUM_IN] | ~sig_in));
    end
  endgenerate
endmodule // mcb_pterm_array

// [hdl/mcb_store.sv]
// Macrocell storage element: D register, T register or D latch
`timescale 1ns/1ps
`include "mcb_map.svh"
module mcb_store import mcb_pkg::*; (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_lvl_in,
  input wire logic pol_in,
  input wire mcb_stype_type stype_in,
  input wire logic d_in,
  input wire logic arst_in,
  input wire logic apre_in,
  output logic q_out
);
  logic q_r;
  logic q_nxt;
  logic act_prev_r;
  logic act_lvl;
  logic rise;

  // ****************************************
  // Next state
  // ****************************************
  // Clock level is already synchronised; an edge is seen in the first core cycle that the level is active
  always_comb begin
    act_lvl = clk_lvl_in ^ pol_in;
    rise = act_lvl & ~act_prev_r;
    q_nxt = q_r;
    if (arst_in) begin
      q_nxt = 1'h0;
    end else if (apre_in) begin
      q_nxt = 1'h1;
    end else begin
      case (stype_in)
        MCB_D_REG: if (rise) q_nxt = d_in;
        MCB_T_REG: if (rise & d_in) q_nxt = ~q_r;
        MCB_D_LATCH: if (!act_lvl) q_nxt = d_in;
        default: q_nxt = q_r;
      endcase
    end
  end

  // Register stage
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_r <= `MCB_Q_RESET;
      act_prev_r <= 1'h0;
    end else begin
      q_r <= q_nxt;
      act_prev_r <= act_lvl;
    end
  end

  assign q_out = q_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  reset_prio_a: assert property (arst_in |=> !q_r)
    else $error("reset term did not clear the storage");
  preset_set_a: assert property (apre_in && !arst_in |=> q_r)
    else $error("preset term did not set the storage");
  dreg_load_a: assert property (stype_in == MCB_D_REG && rise && !arst_in && !apre_in
    |=> q_r == $past(d_in))
    else $error("D register missed its load");
  treg_toggle_a: assert property (stype_in == MCB_T_REG && rise && d_in && !arst_in &&
    !apre_in |=> q_r != $past(q_r))
    else $error("T register did not toggle");
  latch_hold_a: assert property (stype_in == MCB_D_LATCH && act_lvl && !arst_in &&
    !apre_in |=> $stable(q_r))
    else $error("closed latch changed");
endmodule // mcb_store

// [tb/mcb_route_model.sv]
// Routing matrix model: feeds block inputs and loops outputs back
`timescale 1ns/1ps
module mcb_route_model (
  input wire logic [32:0] src_in,
  input wire logic [7:0] fb_in,
  output logic [32:0] route_out
);
  // ****************************************
  // Routing
  // ****************************************
  // Feedback enters only here, on inputs 24..31, so no local shortcut exists
  assign route_out = {src_in[32], fb_in, src_in[23:0]};
endmodule // mcb_route_model

// [tb/test_mcb_logic_block.sv]
// Self-checking bench for the product-term logic block
`timescale 1ns/1ps
module test_mcb_logic_block;
  import mcb_pkg::*;
  localparam int NI = 33;
  localparam int NP = 42;
  logic core_clk_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic [32:0] src = 33'h0;
  logic [32:0] route;
  logic [3:0] blk_clk = 4'h0;
  logic [NP*NI-1:0] and_t;
  logic [NP*NI-1:0] and_c;
  logic [7:0] async_m = 8'h00;
  logic [7:0] ext = 8'hff;
  logic [7:0] xorc = 8'h00;
  logic [7:0] pol = 8'h00;
  logic [7:0] pten = 8'h00;
  logic [7:0] ptinv = 8'h00;
  logic [7:0] dinv = 8'h00;
  logic [15:0] rsel = 16'h0000;
  logic [15:0] stype = 16'hffff;
  logic [15:0] csel = 16'h0000;
  logic [7:0] mc;
  logic [7:0] fb;
  logic [7:0] warn;
  int miscompares = 0;
  int samples_checked = 0;

  // ****************************************
  // Clock, partner and design
  // ****************************************
  always #20 core_clk_in = ~core_clk_in;

  mcb_route_model mcb_route_model_i (.src_in(src), .fb_in(fb), .route_out(route));

  mcb_logic_block #(.NUM_IN(NI), .NUM_MC(8)) mcb_logic_block_i (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .route_in(route),
    .blk_clk_in(blk_clk), .cfg_and_true_in(and_t), .cfg_and_comp_in(and_c),
    .cfg_async_in(async_m), .cfg_extend_in(ext), .cfg_xor_const_in(xorc),
    .cfg_route_in(rsel), .cfg_stype_in(stype), .cfg_clk_sel_in(csel),
    .cfg_clk_pol_in(pol), .cfg_ptclk_en_in(pten), .cfg_ptclk_inv_in(ptinv),
    .cfg_data_inv_in(dinv), .mc_out(mc), .feedback_out(fb), .jk_latch_warn_out(warn)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Inputs change only at the falling edge, away from the sampling edge
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask

  // Mode 0 true literal, 1 complement, 2 both so the term is always 0
  task automatic set_term(input int t, input int i, input int mode);
    wait_cyc(1);
    and_t[t*NI +: NI] = '0;
    and_c[t*NI +: NI] = '0;
    and_t[t*NI+i] = (mode != 1);
    and_c[t*NI+i] = (mode != 0);
  endtask

  // Eight cycles cover the synchroniser, storage and output stages
  task automatic drive(input int i, input logic v);
    wait_cyc(1);
    src[i] = v;
    wait_cyc(8);
  endtask

  // High phase of three core cycles and low phase of six, well over the minimum
  task automatic pulse(input int k);
    wait_cyc(1);
    blk_clk[k] = 1'h1;
    wait_cyc(3);
    blk_clk[k] = 1'h0;
    wait_cyc(6);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_comb();
    set_term(0, 0, 0);
    set_term(25, 24, 0);
    stype[10 +: 2] = MCB_COMB;
    drive(0, 1'h1);
    check(mc[0], 1'h1);
    check(fb[0], 1'h1);
    check(mc[5], 1'h1);
    xorc[0] = 1'h1;
    wait_cyc(8);
    check(mc[0], 1'h0);
    set_term(0, 0, 1);
    wait_cyc(8);
    check(mc[0], 1'h1);
    dinv[0] = 1'h1;
    wait_cyc(8);
    check(mc[0], 1'h0);
    dinv[0] = 1'h0;
    xorc[0] = 1'h0;
    set_term(25, 24, 2);
  endtask

  task automatic t_dreg();
    stype[2 +: 2] = MCB_D_REG;
    csel[2 +: 2] = 2'h2;
    set_term(5, 1, 0);
    drive(1, 1'h1);
    pulse(0);
    check(mc[1], 1'h0);
    pulse(2);
    check(mc[1], 1'h1);
    drive(1, 1'h0);
    pulse(3);
    check(mc[1], 1'h1);
    pulse(2);
    check(mc[1], 1'h0);
  endtask

  task automatic t_treg();
    stype[4 +: 2] = MCB_T_REG;
    csel[4 +: 2] = 2'h1;
    ext[2] = 1'h0;
    set_term(10, 2, 0);
    drive(2, 1'h1);
    pulse(1);
    check(mc[2], 1'h1);
    pulse(1);
    check(mc[2], 1'h0);
    drive(2, 1'h0);
    pulse(1);
    check(mc[2], 1'h0);
  endtask

  task automatic t_latch();
    stype[6 +: 2] = MCB_D_LATCH;
    csel[6 +: 2] = 2'h3;
    ext[3] = 1'h0;
    set_term(15, 3, 0);
    drive(3, 1'h1);
    check(mc[3], 1'h1);
    check(warn[3], 1'h1);
    blk_clk[3] = 1'h1;
    drive(3, 1'h0);
    check(mc[3], 1'h1);
    pol[3] = 1'h1;
    ext[3] = 1'h1;
    wait_cyc(8);
    check(mc[3], 1'h0);
    check(warn[3], 1'h0);
  endtask

  // Macrocell 1 is a D register holding 0 when this starts
  task automatic t_init();
    set_term(41, 4, 0);
    set_term(40, 5, 0);
    drive(4, 1'h1);
    check(mc[1], 1'h1);
    drive(5, 1'h1);
    check(mc[1], 1'h0);
    async_m[1] = 1'h1;
    drive(5, 1'h0);
    check(mc[1], 1'h0);
    drive(4, 1'h0);
    async_m[1] = 1'h0;
    // Clear every synchronous macrocell that the preset left high
    drive(5, 1'h1);
    drive(5, 1'h0);
  endtask

  task automatic t_cluster();
    set_term(23, 6, 0);
    drive(6, 1'h1);
    check(mc[4], 1'h1);
    async_m[4] = 1'h1;
    wait_cyc(8);
    check(mc[4], 1'h0);
    set_term(21, 6, 0);
    wait_cyc(8);
    check(mc[4], 1'h1);
    // Steered to a synchronous macrocell, the cluster keeps its home size
    set_term(21, 6, 2);
    rsel[8 +: 2] = 2'h1;
    wait_cyc(8);
    check(mc[5], 1'h0);
    async_m[4] = 1'h0;
    wait_cyc(8);
    check(mc[5], 1'h1);
    check(mc[4], 1'h0);
    rsel[8 +: 2] = 2'h0;
  endtask

  task automatic t_ptclk();
    async_m[7] = 1'h1;
    pten[7] = 1'h1;
    stype[14 +: 2] = MCB_D_REG;
    set_term(35, 8, 0);
    set_term(37, 7, 0);
    drive(8, 1'h1);
    check(mc[7], 1'h0);
    drive(7, 1'h1);
    check(mc[7], 1'h1);
    ptinv[7] = 1'h1;
    drive(8, 1'h0);
    check(mc[7], 1'h1);
    drive(7, 1'h0);
    check(mc[7], 1'h0);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    for (int t = 0; t < NP; t++) begin
      and_t[t*NI +: NI] = '0;
      and_c[t*NI +: NI] = '0;
      and_t[t*NI+32] = 1'h1;
      and_c[t*NI+32] = 1'h1;
    end
    wait_cyc(4);
    check(mc, 8'h00);
    rst_n_in = 1'h1;
    wait_cyc(2);
    t_comb();
    t_dreg();
    t_treg();
    t_latch();
    t_init();
    t_cluster();
    t_ptclk();
    stop_test();
  end

  // The run needs well under 1000 cycles; 5000 means a hang
  initial begin
    #200000;
    miscompares++;
    stop_test();
  end
endmodule // test_mcb_logic_block
